// ===== logic/remote_output_selector.sv
// Remote output selector: sixteen remote output bits, each routed from a
// status source, an input echo or a general bit by its selection code.
// Assumes an AHB-Lite master on hclk and status and echo levels that are
// asynchronous to hclk, so each passes two flip-flops first.
// Function
// - Code 66 shows the warning state
// - Code 67 shows ready for operation
// - Code 68 shows motor operating
// - Code 69 shows positioning completed
// - Code 70 shows motor at home
// - Code 71 shows load outside torque range
// - Code 72 passes one pulse per 7.2 degrees
// - Codes 73 to 75 show zones 1-3
// - Code 80 shows internal processing busy
// - Code 82 shows main supply, AC only
// - Bits 0-3 reset to 48,49,50,4
// - Bits 4-15 reset to listed codes
// - ON reads as 1, OFF as 0
// - Code 0 gives 0; 65 shows alarm
// - Echo codes follow their input signals
// - Codes 32 to 47 show general bits
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module remote_output_selector
	import remote_output_selector_pkg::*;
#(
	parameter bit AC_VARIANT = 1'b1
)(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	input  wire status_s     status_raw,
	input  wire logic [25:0] echo_raw,
	output logic      [15:0] remote_out,
	output logic             irq
);

	status_s     stat_meta_q;
	status_s     stat_q;
	logic [25:0] echo_meta_q;
	logic [25:0] echo_q;
	logic [7:0]  sel_q [16];
	logic [15:0] general_q;
	logic [15:0] out_q;
	logic [15:0] out_prev_q;
	logic [15:0] evt_q;
	logic [15:0] mask_q;
	logic        wr_pend_q;
	logic        rd_pend_q;
	logic [7:0]  addr_q;
	logic [31:0] hrdata_q;
	logic [15:0] out_d;

	// Selection function; ON is 1 and OFF is 0 throughout
	function automatic logic pick(input logic [7:0] c, input logic [25:0] e,
		input status_s s, input logic [15:0] g);
		logic r;
		r = 1'b0;
		if (c >= CODE_ECHO_A_LO && c <= CODE_ECHO_A_HI)
			r = e[5'(c - CODE_ECHO_A_LO)];
		else if (c >= CODE_ECHO_B_LO && c <= CODE_ECHO_B_HI)
			r = e[5'(c - CODE_ECHO_B_LO) + ECHO_B_BASE];
		else if (c >= CODE_GP_LO && c <= CODE_GP_HI)
			r = g[4'(c - CODE_GP_LO)];
		else if (c >= CODE_ECHO_C_LO && c <= CODE_ECHO_C_HI)
			r = e[5'(c - CODE_ECHO_C_LO) + ECHO_C_BASE];
		else if (c >= CODE_ECHO_D_LO && c <= CODE_ECHO_D_HI)
			r = e[5'(c - CODE_ECHO_D_LO) + ECHO_D_BASE];
		else if (c == CODE_FAULT)
			r = s.fault_flag;
		else if (c == CODE_WARNING)
			r = s.warning_flag;
		else if (c == CODE_READY)
			r = s.ready_flag;
		else if (c == CODE_MOTION)
			r = s.motion_flag;
		else if (c == CODE_POS_DONE)
			r = s.positioning_done_flag;
		else if (c == CODE_HOME)
			r = s.home_flag;
		else if (c == CODE_TORQUE)
			r = s.torque_limit_flag;
		else if (c == CODE_TIMING)
			r = s.shaft_timing_pulse;
		else if (c == CODE_ZONE1)
			r = s.zone_one_flag;
		else if (c == CODE_ZONE2)
			r = s.zone_two_flag;
		else if (c == CODE_ZONE3)
			r = s.zone_three_flag;
		else if (c == CODE_BUSY)
			r = s.internal_processing_flag;
		else if (c == CODE_SUPPLY && AC_VARIANT)
			r = s.main_supply_on_flag;
		return r;
	endfunction

	// Two-stage synchronisers for pin-level sources
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			stat_meta_q <= STATUS_RST;
			stat_q      <= STATUS_RST;
			echo_meta_q <= ECHO_RST;
			echo_q      <= ECHO_RST;
		end
		else
		begin
			stat_meta_q <= status_raw;
			stat_q      <= stat_meta_q;
			echo_meta_q <= echo_raw;
			echo_q      <= echo_meta_q;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++)
		begin : g_bit
			assign out_d[gi] = pick(sel_q[gi], echo_q, stat_q, general_q);
		end
	endgenerate

	// AHB-Lite slave: writes take no wait, reads one wait so hrdata comes from a flop
	wire        accept   = hsel & hready & htrans[1];
	wire        wr_sel   = wr_pend_q && addr_q <= SEL3_OFS;
	wire [1:0]  wr_word  = addr_q[3:2];
	wire        rd_evt   = rd_pend_q && addr_q == EVT_OFS;
	wire [15:0] rise     = out_q & ~out_prev_q;
	wire [31:0] sel_word = {sel_q[{addr_q[3:2], 2'b11}], sel_q[{addr_q[3:2], 2'b10}],
		sel_q[{addr_q[3:2], 2'b01}], sel_q[{addr_q[3:2], 2'b00}]};
	wire [31:0] rd_word  = (addr_q <= SEL3_OFS) ? sel_word :
		(addr_q == GENERAL_OFS) ? {16'h0000, general_q} :
		(addr_q == OUT_OFS) ? {16'h0000, out_q} :
		(addr_q == EVT_OFS) ? {16'h0000, evt_q} :
		(addr_q == MASK_OFS) ? {16'h0000, mask_q} :
		(addr_q == SRC_OFS) ? {19'h0000, stat_q} : 32'h00000000;

	assign hreadyout  = ~rd_pend_q;
	assign hresp      = 1'b0;
	assign hrdata     = hrdata_q;
	assign remote_out = out_q;
	assign irq        = |(evt_q & mask_q);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q    <= 8'h00;
			hrdata_q  <= 32'h00000000;
		end
		else
		begin
			wr_pend_q <= accept & hwrite;
			rd_pend_q <= accept & ~hwrite;
			if (accept)
				addr_q <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hff;
			if (rd_pend_q)
				hrdata_q <= rd_word;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int i = 0; i < 16; i++)
				sel_q[i] <= SEL_RST[i];
			general_q <= GENERAL_RST;
			mask_q    <= MASK_RST;
		end
		else
		begin
			if (wr_sel)
				for (int b = 0; b < 4; b++)
					sel_q[{wr_word, 2'(b)}] <= hwdata[8*b +: 8];
			if (wr_pend_q && addr_q == GENERAL_OFS)
				general_q <= hwdata[15:0];
			if (wr_pend_q && addr_q == MASK_OFS)
				mask_q <= hwdata[15:0];
		end
	end

	// Output bits and edge events; a rising edge in the read-clear cycle survives
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			out_q      <= OUT_RST;
			out_prev_q <= OUT_RST;
			evt_q      <= EVT_RST;
		end
		else
		begin
			out_q      <= out_d;
			out_prev_q <= out_q;
			evt_q      <= (rd_evt ? 16'h0000 : evt_q) | rise;
		end
	end

	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic first_q;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			first_q <= 1'b1;
		else
			first_q <= 1'b0;
	end

	AST_WARNING: assert property (sel_q[6] == CODE_WARNING |=> out_q[6] == $past(stat_q.warning_flag))
		else $error("warning code not followed");
	AST_READY: assert property (sel_q[5] == CODE_READY |=> out_q[5] == $past(stat_q.ready_flag))
		else $error("ready code not followed");
	AST_MOTION: assert property (sel_q[13] == CODE_MOTION |=> out_q[13] == $past(stat_q.motion_flag))
		else $error("motion code not followed");
	AST_DONE: assert property (sel_q[14] == CODE_POS_DONE && stat_q.positioning_done_flag
		|=> out_q[14])
		else $error("completion not shown");
	AST_HOME: assert property (sel_q[4] == CODE_HOME && !stat_q.home_flag |=> !out_q[4])
		else $error("home shown while away");
	AST_TORQUE: assert property (sel_q[15] == CODE_TORQUE |=> out_q[15] == $past(stat_q.torque_limit_flag))
		else $error("torque code not followed");
	AST_TIMING: assert property (sel_q[12] == CODE_TIMING && $past(sel_q[12]) == CODE_TIMING
		&& $rose(stat_q.shaft_timing_pulse) |=> $rose(out_q[12]))
		else $error("timing pulse not passed");
	AST_ZONE: assert property (sel_q[10] == CODE_ZONE2 |=> out_q[10] == $past(stat_q.zone_two_flag))
		else $error("zone code not followed");
	AST_BUSY: assert property (sel_q[8] == CODE_BUSY |=> out_q[8] == $past(stat_q.internal_processing_flag))
		else $error("busy code not followed");
	AST_SUPPLY: assert property (sel_q[0] == CODE_SUPPLY
		|=> out_q[0] == $past(stat_q.main_supply_on_flag & AC_VARIANT))
		else $error("supply code wrong");
	AST_DEFAULTS: assert property (first_q |-> sel_q[0] == CODE_SEL0_ECHO && sel_q[3] == CODE_START
		&& sel_q[4] == CODE_HOME && sel_q[15] == CODE_TORQUE)
		else $error("reset selections wrong");
	AST_NONE: assert property (sel_q[1] == CODE_NONE || sel_q[1] == 8'h40 |=> !out_q[1])
		else $error("unused bit not zero");
	AST_GENERAL: assert property (sel_q[2] == 8'h22 |=> out_q[2] == $past(general_q[2]))
		else $error("general bit not shown");
	AST_ECHO: assert property (sel_q[3] == CODE_START |=> out_q[3] == $past(echo_q[3]))
		else $error("echo not followed");
	AST_SEL_CHANGE: assert property ($changed(sel_q[0]) && sel_q[0] == CODE_GP_LO
		|=> out_q[0] == $past(general_q[0]))
		else $error("new selection late");
	AST_EVT_KEEP: assert property (rd_evt && rise[7] |=> evt_q[7])
		else $error("event lost on read clear");
	AST_IRQ: assert property (evt_q[9] && mask_q[9] |-> irq)
		else $error("irq missing");

	// Further sources and codes; status sources and the bit 0 echo on the bit that selects them after reset
	AST_FAULT: assert property (sel_q[7] == CODE_FAULT |=> out_q[7] == $past(stat_q.fault_flag))
		else $error("fault code not followed");
	AST_ZONE_ONE: assert property (sel_q[9] == CODE_ZONE1 |=> out_q[9] == $past(stat_q.zone_one_flag))
		else $error("zone one code not followed");
	AST_ZONE_THREE: assert property (sel_q[11] == CODE_ZONE3
		|=> out_q[11] == $past(stat_q.zone_three_flag))
		else $error("zone three code not followed");
	AST_DONE_LOW: assert property (sel_q[14] == CODE_POS_DONE
		&& !stat_q.positioning_done_flag |=> !out_q[14])
		else $error("completion shown while operating");
	AST_HOME_SET: assert property (sel_q[4] == CODE_HOME && stat_q.home_flag |=> out_q[4])
		else $error("home not shown");
	AST_ECHO_LOW: assert property (sel_q[0] == CODE_SEL0_ECHO |=> out_q[0] == $past(echo_q[16]))
		else $error("selection echo not followed");
	AST_ECHO_B: assert property (sel_q[9] == CODE_ECHO_B_LO |=> out_q[9] == $past(echo_q[13]))
		else $error("second echo group not followed");
	AST_ECHO_D: assert property (sel_q[11] == CODE_ECHO_D_HI |=> out_q[11] == $past(echo_q[25]))
		else $error("last echo group not followed");
	AST_GEN_TOP: assert property (sel_q[15] == CODE_GP_HI |=> out_q[15] == $past(general_q[15]))
		else $error("top general bit not shown");
	AST_UNDEF: assert property (sel_q[13] == 8'h51 |=> !out_q[13])
		else $error("undefined code not zero");

	// Bus timing and the event register
	AST_READ_WAIT: assert property (rd_pend_q |-> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	AST_WRITE_NOWAIT: assert property (wr_pend_q |-> hreadyout)
		else $error("write stalled");
	AST_EVT_SET: assert property (rise[0] |=> evt_q[0])
		else $error("event not captured");
	AST_EVT_CLEAR: assert property (rd_evt && !rise[3] |=> !evt_q[3])
		else $error("event not cleared");

	COV_WRITE_SEL: cover property (wr_sel ##1 out_q != $past(out_q));
	COV_READ_EVT: cover property (rd_evt ##1 hreadyout);
	COV_IRQ: cover property ($rose(irq));
	COV_TIMING: cover property (sel_q[12] == CODE_TIMING && $rose(out_q[12]));
	COV_EVT_KEEP: cover property (rd_evt && |rise);

endmodule

// ===== logic/remote_output_selector_pkg.sv
// Package for the remote output selector: register map, selection codes,
// reset selections and the carrier struct for the status sources.
// Assumes a single 10 MHz clock domain and a 32-bit AHB-Lite register bus.
package remote_output_selector_pkg;

	// Register byte offsets
	localparam logic [7:0] SEL0_OFS     = 8'h00;
	localparam logic [7:0] SEL1_OFS     = 8'h04;
	localparam logic [7:0] SEL2_OFS     = 8'h08;
	localparam logic [7:0] SEL3_OFS     = 8'h0c;
	localparam logic [7:0] GENERAL_OFS  = 8'h10;
	localparam logic [7:0] OUT_OFS      = 8'h14;
	localparam logic [7:0] EVT_OFS      = 8'h18;
	localparam logic [7:0] MASK_OFS     = 8'h1c;
	localparam logic [7:0] SRC_OFS      = 8'h20;

	// Reset values
	localparam logic [15:0] GENERAL_RST = 16'h0000;
	localparam logic [15:0] MASK_RST    = 16'h0000;
	localparam logic [15:0] EVT_RST     = 16'h0000;
	localparam logic [15:0] OUT_RST     = 16'h0000;

	// Selection codes
	localparam logic [7:0] CODE_NONE      = 8'h00;
	localparam logic [7:0] CODE_ECHO_A_LO = 8'h01;
	localparam logic [7:0] CODE_ECHO_A_HI = 8'h0d;
	localparam logic [7:0] CODE_ECHO_B_LO = 8'h10;
	localparam logic [7:0] CODE_ECHO_B_HI = 8'h12;
	localparam logic [7:0] CODE_GP_LO     = 8'h20;
	localparam logic [7:0] CODE_GP_HI     = 8'h2f;
	localparam logic [7:0] CODE_ECHO_C_LO = 8'h30;
	localparam logic [7:0] CODE_ECHO_C_HI = 8'h35;
	localparam logic [7:0] CODE_ECHO_D_LO = 8'h3c;
	localparam logic [7:0] CODE_ECHO_D_HI = 8'h3f;
	localparam logic [7:0] CODE_START     = 8'h04;
	localparam logic [7:0] CODE_FAULT     = 8'h41;
	localparam logic [7:0] CODE_WARNING   = 8'h42;
	localparam logic [7:0] CODE_READY     = 8'h43;
	localparam logic [7:0] CODE_MOTION    = 8'h44;
	localparam logic [7:0] CODE_POS_DONE  = 8'h45;
	localparam logic [7:0] CODE_HOME      = 8'h46;
	localparam logic [7:0] CODE_TORQUE    = 8'h47;
	localparam logic [7:0] CODE_TIMING    = 8'h48;
	localparam logic [7:0] CODE_ZONE1     = 8'h49;
	localparam logic [7:0] CODE_ZONE2     = 8'h4a;
	localparam logic [7:0] CODE_ZONE3     = 8'h4b;
	localparam logic [7:0] CODE_BUSY      = 8'h50;
	localparam logic [7:0] CODE_SUPPLY    = 8'h52;
	localparam logic [7:0] CODE_SEL0_ECHO = 8'h30;
	localparam logic [7:0] CODE_SEL1_ECHO = 8'h31;
	localparam logic [7:0] CODE_SEL2_ECHO = 8'h32;

	// Echo vector base indices for the B, C and D code groups
	localparam logic [4:0] ECHO_B_BASE = 5'h0d;
	localparam logic [4:0] ECHO_C_BASE = 5'h10;
	localparam logic [4:0] ECHO_D_BASE = 5'h16;

	// Selections after reset, output bit 0 first
	localparam logic [7:0] SEL_RST [16] = '{
		CODE_SEL0_ECHO, CODE_SEL1_ECHO, CODE_SEL2_ECHO, CODE_START,
		CODE_HOME, CODE_READY, CODE_WARNING, CODE_FAULT,
		CODE_BUSY, CODE_ZONE1, CODE_ZONE2, CODE_ZONE3,
		CODE_TIMING, CODE_MOTION, CODE_POS_DONE, CODE_TORQUE};

	typedef struct packed {
		logic       fault_flag;
		logic       warning_flag;
		logic       ready_flag;
		logic       motion_flag;
		logic       positioning_done_flag;
		logic       home_flag;
		logic       torque_limit_flag;
		logic       shaft_timing_pulse;
		logic       zone_one_flag;
		logic       zone_two_flag;
		logic       zone_three_flag;
		logic       internal_processing_flag;
		logic       main_supply_on_flag;
	} status_s;

	localparam status_s STATUS_RST = '0;
	localparam logic [25:0] ECHO_RST = 26'h0;

endpackage

// ===== verification/remote_reader.sv
// Partner model: the network master that polls the remote output bits.
// Assumes remote_out is a registered level on hclk.
`timescale 1ns/10ps
module remote_reader
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic [15:0] remote_out,
	output logic      [15:0] seen_q
);
	// ON is taken as 1 and OFF as 0, no inversion on the link
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			seen_q <= 16'h0000;
		else
			seen_q <= remote_out;
	end
endmodule

// ===== verification/remote_output_selector_bench.sv
// Bench for the remote output selector: AHB-Lite register tasks and
// level checks of the remote output bits through the polling partner.
// Assumes one slave, so hready is fed back from hreadyout.
`timescale 1ns/10ps
module remote_output_selector_bench;
	import remote_output_selector_pkg::*;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	status_s     status_raw = '0;
	logic [25:0] echo_raw = 26'h0;
	logic [15:0] remote_out;
	logic        irq;
	logic [15:0] seen_q;
	logic [31:0] rd;
	int          n_errors = 0;
	int          comparisons = 0;
	int          cycles = 0;
	// Status codes in the order of the status struct, fault first
	localparam logic [7:0]  SCODE [13] = '{8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48,
		8'h49, 8'h4a, 8'h4b, 8'h50, 8'h52};
	localparam logic [7:0]  UNDEF [5] = '{8'h00, 8'h0e, 8'h40, 8'h51, 8'hff};
	localparam logic [31:0] DEF [4] = '{32'h04323130, 32'h41424346, 32'h4b4a4950, 32'h47454448};

	remote_output_selector remote_output_selector_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.status_raw(status_raw), .echo_raw(echo_raw), .remote_out(remote_out), .irq(irq));
	remote_reader remote_reader_inst (.hclk(hclk), .hresetn(hresetn), .remote_out(remote_out),
		.seen_q(seen_q));

	always #50 hclk = ~hclk;

	task automatic test_done();
		if (n_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// A hang is cut short well beyond the expected run length
	always @(posedge hclk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			n_errors++;
			test_done();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Ready and read data are taken as they stood at the sampling edge; the slave updates them non-blocking
	task automatic wait_ready();
		do
			@(posedge hclk);
		while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic ahb_write(input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= 1'b1;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
	endtask

	task automatic ahb_read(input logic [7:0] a);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= 1'b0;
		wait_ready();
		htrans <= 2'h0;
		wait_ready();
	endtask

	task automatic set_all(input logic [7:0] c);
		for (int n = 0; n < 4; n++)
			ahb_write(8'(4 * n), {4{c}});
	endtask

	// Three edges through the input path plus one in the partner
	task automatic check_out(input logic [15:0] exp);
		repeat (4) @(posedge hclk);
		@(negedge hclk);
		check({16'h0, seen_q}, {16'h0, exp});
		@(posedge hclk);
	endtask

	function automatic logic [7:0] ecode(input int k);
		if (k < 13)
			return 8'(k + 1);
		if (k < 16)
			return 8'(k + 3);
		if (k < 22)
			return 8'(k + 32);
		return 8'(k + 38);
	endfunction

	initial
	begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int n = 0; n < 4; n++)
		begin
			ahb_read(8'(4 * n));
			check(rd, DEF[n]);
		end
		status_raw <= '1;
		check_out(16'hfff0);
		echo_raw <= 26'h070008;
		check_out(16'hffff);
		status_raw <= '0;
		check_out(16'h000f);
		for (int i = 0; i < 13; i++)
		begin
			set_all(SCODE[i]);
			status_raw <= status_s'(13'h1 << (12 - i));
			check_out(16'hffff);
			status_raw <= status_s'(~(13'h1 << (12 - i)));
			check_out(16'h0000);
		end
		for (int k = 0; k < 26; k++)
		begin
			set_all(ecode(k));
			echo_raw <= 26'h1 << k;
			check_out(16'hffff);
			echo_raw <= ~(26'h1 << k);
			check_out(16'h0000);
		end
		status_raw <= '1;
		echo_raw <= '1;
		for (int u = 0; u < 5; u++)
		begin
			set_all(UNDEF[u]);
			check_out(16'h0000);
		end
		ahb_write(GENERAL_OFS, 32'h0000a5c3);
		for (int n = 0; n < 4; n++)
			ahb_write(8'(4 * n), {8'(35 + 4 * n), 8'(34 + 4 * n), 8'(33 + 4 * n), 8'(32 + 4 * n)});
		check_out(16'ha5c3);
		ahb_write(GENERAL_OFS, 32'h00005a3c);
		check_out(16'h5a3c);
		status_raw <= '0;
		set_all(8'h41);
		ahb_write(MASK_OFS, 32'h0);
		ahb_read(EVT_OFS);
		status_raw <= status_s'(13'h1000);
		check_out(16'hffff);
		check({31'h0, irq}, 32'h0);
		ahb_write(MASK_OFS, 32'h0000ffff);
		check_out(16'hffff);
		check({31'h0, irq}, 32'h1);
		ahb_read(EVT_OFS);
		check(rd, 32'h0000ffff);
		check_out(16'hffff);
		check({31'h0, irq}, 32'h0);
		ahb_write(OUT_OFS, 32'h0);
		ahb_read(OUT_OFS);
		check(rd, 32'h0000ffff);
		ahb_read(SRC_OFS);
		check(rd, 32'h00001000);
		ahb_write(8'h40, 32'hffffffff);
		ahb_read(8'h40);
		check(rd, 32'h0);
		check({31'h0, hresp}, 32'h0);
		// A rise in the very cycle of a read-clear must survive to the next read
		status_raw <= '0;
		check_out(16'h0000);
		status_raw <= status_s'(13'h1000);
		repeat (2) @(posedge hclk);
		ahb_read(EVT_OFS);
		check(rd, 32'h0);
		ahb_read(EVT_OFS);
		check(rd, 32'h0000ffff);
		test_done();
	end
endmodule
